// file: src/fs2_dev.sv
// fs2_dev: status-two and config-one register bank of the flash
// assumes: array engine on pclk drives the activity inputs
// How it works
// R1 - status two read by 07h or 65h
// R2 - status two read-only, bits 7..3 zero
// R3 - bit 2 holds latest erase-check result
// R4 - host checks erase before reading status
// R5 - bit 1 shows erase suspended
// R6 - bit 0 shows program suspended
// R7 - config one written by 01h or 71h
// R8 - config bits 7,6,4 always zero
// R9 - origin bit: 0 top, 1 bottom
// R10 - one-time bits never clear, no error
// R11 - nonvolatile protect written with long time
// R12 - volatility set loads protect bits 111
// R13 - volatile mode writes volatile protect, short
// R14 - parameter bit: 1 top, 0 bottom
// R15 - uniform map ignores parameter bit
// R16 - origin and parameter bits independent
// R17 - quad default written by both commands
// R18 - nonvolatile four-wire sets quad default
// R19 - active four-wire refuses quad default clear
// R20 - freeze default reads zero, unwritable
// R21 - host sets one-time bits before array use
// R22 - freeze blocks one-time writes, no error
// R23 - writes need write enable latch set
// R24 - suspend flags clear on resume, reset
`timescale 1ns/1ps
`include "fs2_map.svh"
module fs2_dev import fs2_pkg::*; #(
	parameter int NV_CYC = (`FS2_TNV_NS + `FS2_CLK_NS - 1) / `FS2_CLK_NS,
	parameter int VW_CYC = (`FS2_TCS_NS + `FS2_CLK_NS - 1) / `FS2_CLK_NS
) (
	// clock and reset
	input  wire logic  pclk,
	input  wire logic  presetn,
	// link
	fs2_link_if.dev    link,
	// array engine state
	input  wire logic  erase_active,     // erase running
	input  wire logic  program_active,   // program running
	input  wire logic  sector_erase_ok,  // selected sector erased
	input  wire logic  hybrid_map,       // 1 hybrid, 0 uniform
	// decoded configuration and status
	output logic       protect_from_bottom,
	output logic       params_at_top,
	output logic [2:0] protect_range_bits,
	output logic       quad_mode,
	output logic       freeze,
	output logic       four_wire,
	output logic       erase_suspended,
	output logic       program_suspended,
	output logic       write_busy
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	fs2_dst_e    st_q;              // sequencer
	logic [15:0] cnt_q;             // write time left
	logic        wel_q;             // write enable latch
	logic        cmd_ready_q;       // link ready
	logic        rsp_valid_q;       // link answer pulse
	fs2_byte_t   rsp_data_q;        // link answer
	logic        tbprot_q, bpnv_q, tbparm_q;  // one-time bits
	logic        quad_width_default_q, qpi_nv_q;         // nonvolatile defaults
	logic [2:0]  protect_range_nonvolatile_q, bp_v_q;             // protect ranges
	logic        quad_v_q, qpi_v_q, frz_q;    // volatile copies
	logic        erase_result_flag_q, es_q, ps_q;         // status two flags
	// ----------------------------------------
	// decode
	// ----------------------------------------
	logic        acc, is_wrr, is_write_any_register_cmd, is_rd, srst;
	logic        w_config_one_nonvolatile, w_config_one_volatile, w_config_two_nonvolatile, w_config_two_volatile, w_hit, nv_time;
	fs2_byte_t   cr1_b, rd_b, status_two_volatile, config_one_nonvolatile;
	logic        tbprot_d, bpnv_d, tbparm_d, quad_width_default_d, qpi_nv_d;
	logic [2:0]  protect_range_nonvolatile_d;
	// status two and config one images
	assign status_two_volatile  = {5'h00, erase_result_flag_q, es_q, ps_q}; // R2
	assign config_one_nonvolatile = {2'h0, tbprot_q, 1'b0, bpnv_q, tbparm_q, quad_width_default_q,
		1'b0}; // R8 R20
	// command decode and next nonvolatile values
	always_comb begin
		acc     = link.cmd_valid & cmd_ready_q;
		is_wrr  = acc & wel_q & (link.cmd_op == `FS2_OP_WRR);   // R7 R23
		is_write_any_register_cmd = acc & wel_q & (link.cmd_op == `FS2_OP_WRITE_ANY_REGISTER_CMD);  // R7 R23
		is_rd   = acc & ((link.cmd_op == `FS2_OP_READ_STATUS_TWO_CMD) |
			(link.cmd_op == `FS2_OP_READ_ANY_REGISTER_CMD));
		srst    = acc & (link.cmd_op == `FS2_OP_SRST);
		w_config_one_nonvolatile = is_wrr | (is_write_any_register_cmd & (link.cmd_addr == `FS2_A_CONFIG_ONE_NONVOLATILE));
		w_config_one_volatile  = is_write_any_register_cmd & (link.cmd_addr == `FS2_A_CONFIG_ONE_VOLATILE);
		w_config_two_nonvolatile = is_write_any_register_cmd & (link.cmd_addr == `FS2_A_CONFIG_TWO_NONVOLATILE);
		w_config_two_volatile  = is_write_any_register_cmd & (link.cmd_addr == `FS2_A_CONFIG_TWO_VOLATILE);
		w_hit   = is_wrr | w_config_one_nonvolatile | w_config_one_volatile | w_config_two_nonvolatile | w_config_two_volatile;
		// wrr carries config one in the upper byte
		cr1_b   = is_wrr ? link.cmd_data[15:8] : link.cmd_data[7:0];
		// one-time bits only ever go to one
		tbprot_d = tbprot_q | (w_config_one_nonvolatile & ~frz_q & cr1_b[`FS2_B_TBPROT]); // R9 R10 R22
		bpnv_d   = bpnv_q | (w_config_one_nonvolatile & ~frz_q & cr1_b[`FS2_B_BPNV]);     // R10 R22
		tbparm_d = tbparm_q | (w_config_one_nonvolatile & ~frz_q & cr1_b[`FS2_B_TBPARM]); // R10 R16 R22
		qpi_nv_d = qpi_nv_q | (w_config_two_nonvolatile & link.cmd_data[`FS2_B_QPI]);
		// quad default follows writes unless four-wire is active and the write clears it
		quad_width_default_d = quad_width_default_q;
		if (w_config_one_nonvolatile & ~(qpi_v_q & ~cr1_b[`FS2_B_QUAD])) begin
			quad_width_default_d = cr1_b[`FS2_B_QUAD]; // R17 R19
		end
		if (qpi_nv_d & ~qpi_nv_q) begin
			quad_width_default_d = 1'b1; // R18
		end
		// nonvolatile protect range
		protect_range_nonvolatile_d = protect_range_nonvolatile_q;
		if (is_wrr & ~frz_q & ~bpnv_q) begin
			protect_range_nonvolatile_d = link.cmd_data[4:2]; // R11
		end
		if (bpnv_d & ~bpnv_q) begin
			protect_range_nonvolatile_d = `FS2_BP_ALL; // R12
		end
		// long time when nonvolatile cells change
		nv_time = (is_wrr & ~bpnv_q & ~frz_q) | (tbprot_d != tbprot_q) |
			(bpnv_d != bpnv_q) | (tbparm_d != tbparm_q) |
			(quad_width_default_d != quad_width_default_q) | (qpi_nv_d != qpi_nv_q); // R11 R13
		// read mux
		case (link.cmd_addr)
			`FS2_A_SR1V:  rd_b = {3'h0, bp_v_q, wel_q, ~st_q[0]};
			`FS2_A_STATUS_TWO_VOLATILE:  rd_b = status_two_volatile;
			`FS2_A_CONFIG_ONE_NONVOLATILE: rd_b = config_one_nonvolatile;
			`FS2_A_CONFIG_ONE_VOLATILE:  rd_b = {2'h0, tbprot_q, 1'b0, bpnv_q, tbparm_q,
				quad_v_q, frz_q};
			`FS2_A_CONFIG_TWO_NONVOLATILE: rd_b = {1'b0, qpi_nv_q, 6'h00};
			`FS2_A_CONFIG_TWO_VOLATILE:  rd_b = {1'b0, qpi_v_q, 6'h00};
			default:      rd_b = 8'h00;       // unmapped reads zero
		endcase
		if (link.cmd_op == `FS2_OP_READ_STATUS_TWO_CMD) begin
			rd_b = status_two_volatile; // R1
		end
	end
	// ----------------------------------------
	// sequencer, write timer, enable latch
	// ----------------------------------------
	// busy for the write time, ready only when idle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q        <= FS2_D_IDLE;
			cnt_q       <= 16'h0000;
			wel_q       <= 1'b0;
			cmd_ready_q <= 1'b0;
		end else begin
			case (st_q)
				FS2_D_IDLE: begin
					cmd_ready_q <= 1'b1;
					if (acc & (link.cmd_op == `FS2_OP_WRITE_ENABLE_CMD)) begin
						wel_q <= 1'b1; // R23
					end
					if (srst) begin
						wel_q <= 1'b0;
					end
					if (w_hit) begin
						st_q        <= FS2_D_BUSY;
						cmd_ready_q <= 1'b0;
						cnt_q <= nv_time ? 16'(NV_CYC) : 16'(VW_CYC); // R11 R13
					end
				end
				FS2_D_BUSY: begin
					cnt_q <= cnt_q - 16'h0001;
					if (cnt_q <= 16'h0001) begin
						st_q <= FS2_D_DONE;
					end
				end
				FS2_D_DONE: begin
					wel_q       <= 1'b0;  // cleared after a write
					cmd_ready_q <= 1'b1;
					st_q        <= FS2_D_IDLE;
				end
				default: begin
					st_q <= FS2_D_IDLE;
				end
			endcase
		end
	end
	// ----------------------------------------
	// nonvolatile cells
	// ----------------------------------------
	// power-on is the only reset that touches them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tbprot_q  <= 1'b0;
			bpnv_q    <= 1'b0;
			tbparm_q  <= 1'b0;
			quad_width_default_q <= 1'b0;
			qpi_nv_q  <= 1'b0;
			protect_range_nonvolatile_q   <= 3'h0;
		end else begin
			tbprot_q  <= tbprot_d;
			bpnv_q    <= bpnv_d;
			tbparm_q  <= tbparm_d;
			quad_width_default_q <= quad_width_default_d;
			qpi_nv_q  <= qpi_nv_d;
			protect_range_nonvolatile_q   <= protect_range_nonvolatile_d;
		end
	end
	// ----------------------------------------
	// volatile copies
	// ----------------------------------------
	// command reset reloads from nonvolatile, freeze survives it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bp_v_q   <= 3'h0;
			quad_v_q <= 1'b0;
			qpi_v_q  <= 1'b0;
			frz_q    <= 1'b0; // R20
		end else if (srst) begin
			bp_v_q   <= protect_range_nonvolatile_q; // R12
			quad_v_q <= quad_width_default_q;
			qpi_v_q  <= qpi_nv_q;
		end else begin
			if (is_wrr & ~frz_q) begin
				bp_v_q <= link.cmd_data[4:2]; // R11 R13
			end
			if (w_config_one_nonvolatile) begin
				quad_v_q <= quad_width_default_d;
			end
			if (w_config_one_volatile & ~(qpi_v_q & ~link.cmd_data[`FS2_B_QUAD])) begin
				quad_v_q <= link.cmd_data[`FS2_B_QUAD]; // R19
			end
			if (w_config_two_volatile) begin
				qpi_v_q <= link.cmd_data[`FS2_B_QPI];
			end
			if ((is_wrr & link.cmd_data[8 + `FS2_B_FREEZE]) |
				(w_config_one_volatile & link.cmd_data[`FS2_B_FREEZE])) begin
				frz_q <= 1'b1;
			end
		end
	end
	// ----------------------------------------
	// status two flags
	// ----------------------------------------
	// only commands and the engine move them, never a write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			erase_result_flag_q <= 1'b0;
			es_q    <= 1'b0; // R24
			ps_q    <= 1'b0; // R24
		end else if (srst) begin
			es_q <= 1'b0; // R24
			ps_q <= 1'b0; // R24
		end else if (acc) begin
			if (link.cmd_op == `FS2_OP_ERASE_RESULT_FLAG) begin
				erase_result_flag_q <= sector_erase_ok; // R3
			end
			if (link.cmd_op == `FS2_OP_SUSP) begin
				if (erase_active) begin
					es_q <= 1'b1; // R5
				end else if (program_active) begin
					ps_q <= 1'b1; // R6
				end
			end
			if (link.cmd_op == `FS2_OP_RESUME) begin
				es_q <= 1'b0; // R24
				ps_q <= 1'b0; // R24
			end
		end
	end
	// ----------------------------------------
	// read answer
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rsp_valid_q <= 1'b0;
			rsp_data_q  <= `FS2_RST_STATUS_TWO_VOLATILE;
		end else begin
			rsp_valid_q <= is_rd; // R1
			if (is_rd) begin
				rsp_data_q <= rd_b;
			end
		end
	end
	assign link.cmd_ready = cmd_ready_q;
	assign link.rsp_valid = rsp_valid_q;
	assign link.rsp_data  = rsp_data_q;
	// ----------------------------------------
	// decoded outputs, registered
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			protect_from_bottom <= 1'b0;
			params_at_top       <= 1'b0;
			protect_range_bits  <= 3'h0;
			quad_mode           <= 1'b0;
			freeze              <= 1'b0;
			four_wire           <= 1'b0;
			erase_suspended     <= 1'b0;
			program_suspended   <= 1'b0;
			write_busy          <= 1'b0;
		end else begin
			protect_from_bottom <= tbprot_q;              // R9
			params_at_top       <= tbparm_q & hybrid_map; // R14 R15
			protect_range_bits  <= bpnv_q ? bp_v_q : protect_range_nonvolatile_q; // R11 R13
			quad_mode           <= quad_v_q;
			freeze              <= frz_q;
			four_wire           <= qpi_v_q;
			erase_suspended     <= es_q;
			program_suspended   <= ps_q;
			write_busy          <= ~st_q[0];
		end
	end
endmodule // fs2_dev

// file: include/fs2_map.svh
// fs2_map.svh: opcodes, register indices, bit positions, timing
// assumes: included by bare name, after nothing else
`ifndef FS2_MAP_SVH
`define FS2_MAP_SVH
// ----------------------------------------
// command opcodes
// ----------------------------------------
`define FS2_OP_WRR      8'h01
`define FS2_OP_READ_STATUS_TWO_CMD    8'h07
`define FS2_OP_READ_ANY_REGISTER_CMD     8'h65
`define FS2_OP_WRITE_ANY_REGISTER_CMD     8'h71
`define FS2_OP_WRITE_ENABLE_CMD     8'h06
`define FS2_OP_ERASE_RESULT_FLAG    8'hd0
`define FS2_OP_SUSP     8'hb0
`define FS2_OP_RESUME   8'h30
`define FS2_OP_SRST     8'hf0
// ----------------------------------------
// register indices on the link
// ----------------------------------------
`define FS2_A_SR1V      8'h00
`define FS2_A_STATUS_TWO_VOLATILE      8'h01
`define FS2_A_CONFIG_ONE_NONVOLATILE     8'h02
`define FS2_A_CONFIG_ONE_VOLATILE      8'h03
`define FS2_A_CONFIG_TWO_NONVOLATILE     8'h04
`define FS2_A_CONFIG_TWO_VOLATILE      8'h05
// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define FS2_B_ERASE_RESULT_FLAG     2
`define FS2_B_ES        1
`define FS2_B_PS        0
`define FS2_B_TBPROT    5
`define FS2_B_BPNV      3
`define FS2_B_TBPARM    2
`define FS2_B_QUAD      1
`define FS2_B_FREEZE    0
`define FS2_B_QPI       6
`define FS2_RST_STATUS_TWO_VOLATILE    8'h00
`define FS2_RST_CONFIG_ONE_NONVOLATILE   8'h00
`define FS2_BP_ALL      3'h7
// ----------------------------------------
// timing
// ----------------------------------------
`define FS2_CLK_NS      10
`define FS2_TNV_NS      5000
`define FS2_TCS_NS      50
// ----------------------------------------
// controller apb offsets
// ----------------------------------------
`define FS2_HA_CMD      12'h000
`define FS2_HA_DATA     12'h004
`define FS2_HA_STAT     12'h008
`endif

// file: include/fs2_pkg.sv
// fs2_pkg: types shared by both ends
// assumes: nothing
package fs2_pkg;
	typedef logic [7:0] fs2_byte_t;   // one register byte
	// device sequencer
	typedef enum logic [2:0] {
		FS2_D_IDLE = 3'b001,
		FS2_D_BUSY = 3'b010,
		FS2_D_DONE = 3'b100
	} fs2_dst_e;
	// controller sequencer
	typedef enum logic [2:0] {
		FS2_H_IDLE = 3'b001,
		FS2_H_REQ  = 3'b010,
		FS2_H_RSP  = 3'b100
	} fs2_hst_e;
endpackage

// file: include/fs2_link_if.sv
// fs2_link_if: command link between controller and register bank
// assumes: both ends clocked by the same pclk
`timescale 1ns/1ps
interface fs2_link_if;
	logic        cmd_valid;   // command offered
	logic        cmd_ready;   // device takes it
	logic [7:0]  cmd_op;      // opcode
	logic [7:0]  cmd_addr;    // register index for any-register ops
	logic [15:0] cmd_data;    // write data, two bytes
	logic        rsp_valid;   // read answer pulse
	logic [7:0]  rsp_data;    // read answer byte
	modport dev  (input cmd_valid, cmd_op, cmd_addr, cmd_data,
		output cmd_ready, rsp_valid, rsp_data);
	modport host (output cmd_valid, cmd_op, cmd_addr, cmd_data,
		input cmd_ready, rsp_valid, rsp_data);
endinterface

// file: src/fs2_host.sv
// fs2_host: apb-driven controller issuing register commands
// assumes: software sends write enable before writes
`timescale 1ns/1ps
`include "fs2_map.svh"
module fs2_host import fs2_pkg::*; (
	// clock and reset
	input  wire logic   pclk,
	input  wire logic   presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// link
	fs2_link_if.host    link
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	fs2_hst_e    st_q;        // sequencer
	logic [7:0]  op_q;        // opcode
	logic [7:0]  addr_q;      // register index
	logic [15:0] data_q;      // write data
	logic        done_q;      // sticky completion
	fs2_byte_t   rd_q;        // last answer
	logic        wr_cmd, is_rd_op, hit;
	// ----------------------------------------
	// apb slave, no wait states
	// ----------------------------------------
	assign wr_cmd = psel & penable & pready & pwrite &
		(paddr == `FS2_HA_CMD) & st_q[0];
	assign hit = (paddr == `FS2_HA_CMD) | (paddr == `FS2_HA_DATA) |
		(paddr == `FS2_HA_STAT);
	// answer in the access cycle after setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~hit;
			case (paddr)
				`FS2_HA_CMD:  prdata <= {16'h0000, addr_q, op_q};
				`FS2_HA_DATA: prdata <= {16'h0000, data_q};
				`FS2_HA_STAT: prdata <= {16'h0000, rd_q, 6'h00, done_q,
					~st_q[0]};
				default:      prdata <= 32'h0000_0000;
			endcase
		end
	end
	// data register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_q <= 16'h0000;
		end else if (psel & penable & pready & pwrite &
			(paddr == `FS2_HA_DATA)) begin
			data_q <= pwdata[15:0];
		end
	end
	// ----------------------------------------
	// command sequencer
	// ----------------------------------------
	assign is_rd_op = (op_q == `FS2_OP_READ_STATUS_TWO_CMD) | (op_q == `FS2_OP_READ_ANY_REGISTER_CMD); // R1
	// offer command until taken, then wait for a read answer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q   <= FS2_H_IDLE;
			op_q   <= 8'h00;
			addr_q <= 8'h00;
			done_q <= 1'b0;
			rd_q   <= 8'h00;
		end else begin
			case (st_q)
				FS2_H_IDLE: begin
					if (wr_cmd) begin
						op_q   <= pwdata[7:0];   // R7 R23
						addr_q <= pwdata[15:8];
						done_q <= 1'b0;
						st_q   <= FS2_H_REQ;
					end
				end
				FS2_H_REQ: begin
					if (link.cmd_ready) begin
						st_q <= is_rd_op ? FS2_H_RSP : FS2_H_IDLE;
						done_q <= ~is_rd_op;
					end
				end
				FS2_H_RSP: begin
					if (link.rsp_valid) begin
						rd_q   <= link.rsp_data;
						done_q <= 1'b1;
						st_q   <= FS2_H_IDLE;
					end
				end
				default: begin
					st_q <= FS2_H_IDLE;
				end
			endcase
		end
	end
	assign link.cmd_valid = st_q[1];
	assign link.cmd_op    = op_q;
	assign link.cmd_addr  = addr_q;
	assign link.cmd_data  = data_q;
endmodule // fs2_host

// file: bench/fs2_checker.sv
// fs2_checker: link-level properties between controller and bank
// assumes: instantiated beside fs2_link_if, one pclk domain
`timescale 1ns/1ps
`include "fs2_map.svh"
module fs2_checker (
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// link signals
	input wire logic        cmd_valid,
	input wire logic        cmd_ready,
	input wire logic [7:0]  cmd_op,
	input wire logic [7:0]  cmd_addr,
	input wire logic [15:0] cmd_data,
	input wire logic        rsp_valid,
	input wire logic [7:0]  rsp_data
);
	localparam int LIM = 40;  // bound above the 9-cycle worst write time with the small counts
	// ----------------------------------------
	// helper decode
	// ----------------------------------------
	wire logic take  = cmd_valid && cmd_ready;  // command taken
	wire logic rd_tk = take && (cmd_op == `FS2_OP_READ_STATUS_TWO_CMD ||
		cmd_op == `FS2_OP_READ_ANY_REGISTER_CMD);                 // read taken
	wire logic wr_op = cmd_op == `FS2_OP_WRR || cmd_op == `FS2_OP_WRITE_ANY_REGISTER_CMD;
	wire logic sr2   = cmd_op == `FS2_OP_READ_STATUS_TWO_CMD || cmd_addr == `FS2_A_STATUS_TWO_VOLATILE;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	AST_RD_ANSWER: assert property (rd_tk |=> rsp_valid)
		else $error("read taken without answer");
	AST_RSP_CAUSE: assert property (rsp_valid |-> $past(rd_tk))
		else $error("answer without read");
	AST_RSP_PULSE: assert property (rsp_valid |=> !rsp_valid)
		else $error("answer longer than one cycle");
	AST_DATA_HOLD: assert property (!rsp_valid |-> $stable(rsp_data))
		else $error("answer byte moved between reads");
	AST_SR2_RSVD: assert property (rd_tk && sr2 |=> rsp_data[7:3] == 5'h00)
		else $error("status two reserved bits set");
	AST_CR1_RSVD: assert property (rd_tk && cmd_op == `FS2_OP_READ_ANY_REGISTER_CMD &&
		cmd_addr == `FS2_A_CONFIG_ONE_NONVOLATILE |=> rsp_data[7:6] == 2'h0 && !rsp_data[4] &&
		!rsp_data[0]) else $error("config one fixed bits set");
	AST_BUSY_CAUSE: assert property ($fell(cmd_ready) |->
		$past(take && wr_op)) else $error("busy without a write");
	AST_BUSY_BOUND: assert property ($fell(cmd_ready) |->
		##[1:LIM] cmd_ready) else $error("write time overran");
	AST_HOLD: assert property (cmd_valid && !cmd_ready |=> cmd_valid &&
		$stable(cmd_op) && $stable(cmd_addr) && $stable(cmd_data))
		else $error("command changed before taken");
endmodule // fs2_checker

// file: bench/testbench.sv
// testbench: apb-driven controller against the register bank
// assumes: both ends joined by fs2_link_if, small write counts
`timescale 1ns/1ps
`include "fs2_map.svh"
module testbench;
	logic        pclk = 0, presetn = 0;           // clock, reset
	logic        psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, r, t;
	logic        pready, pslverr, err;
	logic        erase_active = 0, program_active = 0;
	logic        sector_erase_ok = 0, hybrid_map = 0;
	logic        pfb, pat, freeze;                // decoded config
	logic [2:0]  prb;                             // protect range
	logic        quad, fw, esus, psus, wbusy;     // status outputs
	logic [31:0] seed = 32'h0000dd2f;             // xorshift state
	logic [7:0]  q[$], ex, m;                     // expected answers
	int          n_fail = 0, n_checks = 0, cyc = 0;
	always #5 pclk = ~pclk;
	// ----------------------------------------
	// design and checker
	// ----------------------------------------
	fs2_link_if lk();
	fs2_host fs2_host_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .link(lk));
	fs2_dev #(.NV_CYC(8), .VW_CYC(2)) fs2_dev_i (.pclk(pclk),
		.presetn(presetn), .link(lk), .erase_active(erase_active),
		.program_active(program_active), .sector_erase_ok(sector_erase_ok),
		.hybrid_map(hybrid_map), .protect_from_bottom(pfb),
		.params_at_top(pat), .protect_range_bits(prb), .quad_mode(quad),
		.freeze(freeze), .four_wire(fw), .erase_suspended(esus),
		.program_suspended(psus), .write_busy(wbusy));
	fs2_checker fs2_checker_i (.pclk(pclk), .presetn(presetn),
		.cmd_valid(lk.cmd_valid), .cmd_ready(lk.cmd_ready),
		.cmd_op(lk.cmd_op), .cmd_addr(lk.cmd_addr), .cmd_data(lk.cmd_data),
		.rsp_valid(lk.rsp_valid), .rsp_data(lk.rsp_data));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input string nm, input logic [7:0] s, e);
		n_checks++;
		if (s !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task report_and_stop;
		if (n_fail == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// one apb transfer, held until pready sampled high
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// issue a link command, wait for idle and done
	task automatic cmd(input logic [7:0] op, a, input logic [15:0] d);
		apb(1, `FS2_HA_DATA, {16'h0, d});
		apb(1, `FS2_HA_CMD, {16'h0, a, op});
		do apb(0, `FS2_HA_STAT, 32'h0); while (r[1:0] !== 2'b10);
	endtask
	task automatic rd(input logic [7:0] op, a, e);
		q.push_back(e);
		cmd(op, a, 16'h0);
		chk("stat_byte", r[15:8], e);
	endtask
	task automatic wr(input logic [7:0] op, a, input logic [15:0] d);
		cmd(`FS2_OP_WRITE_ENABLE_CMD, 8'h00, 16'h0);
		cmd(op, a, d);
	endtask
	// ----------------------------------------
	// answer monitor and timeout
	// ----------------------------------------
	always @(posedge pclk) begin
		if (lk.rsp_valid === 1'b1) begin
			if (q.size() == 0) chk("rsp_extra", 8'h01, 8'h00);
			else chk("rsp_data", lk.rsp_data, q.pop_front());
		end
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc > 30000) begin
			n_fail++;
			report_and_stop();
		end
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1;
		// reset values through both read paths
		rd(`FS2_OP_READ_STATUS_TWO_CMD, 8'h00, 8'h00);
		rd(`FS2_OP_READ_ANY_REGISTER_CMD, `FS2_A_STATUS_TWO_VOLATILE, 8'h00);
		rd(`FS2_OP_READ_ANY_REGISTER_CMD, `FS2_A_CONFIG_ONE_NONVOLATILE, 8'h00);
		// suspend table: erase only, program only, both
		for (int i = 0; i < 3; i++) begin
			erase_active <= (i != 1);
			program_active <= (i != 0);
			cmd(`FS2_OP_SUSP, 8'h00, 16'h0);
			rd(`FS2_OP_READ_STATUS_TWO_CMD, 8'h00, {6'h0, i != 1, i == 1});
			chk("susp", {6'h0, esus, psus}, {6'h0, i != 1, i == 1});
			cmd(`FS2_OP_RESUME, 8'h00, 16'h0);
			erase_active <= 0;
			program_active <= 0;
			rd(`FS2_OP_READ_STATUS_TWO_CMD, 8'h00, 8'h00);
			chk("resumed", {6'h0, esus, psus}, 8'h00);
		end
		// erase check result both ways
		for (int i = 0; i < 2; i++) begin
			sector_erase_ok <= i[0];
			cmd(`FS2_OP_ERASE_RESULT_FLAG, 8'h00, 16'h0);
			rd(`FS2_OP_READ_STATUS_TWO_CMD, 8'h00, {5'h0, i[0], 2'h0});
		end
		// freeze blocks one-time bits, then hardware reset
		wr(`FS2_OP_WRR, 8'h00, 16'h0100);
		chk("busy", {7'h0, wbusy}, 8'h01);
		wr(`FS2_OP_WRITE_ANY_REGISTER_CMD, `FS2_A_CONFIG_ONE_NONVOLATILE, 16'h002c);
		rd(`FS2_OP_READ_ANY_REGISTER_CMD, `FS2_A_CONFIG_ONE_NONVOLATILE, 8'h00);
		chk("idle", {7'h0, wbusy}, 8'h00);
		chk("freeze", {7'h0, freeze}, 8'h01);
		@(posedge pclk);
		presetn <= 0;
		repeat (2) @(posedge pclk);
		presetn <= 1;
		// write without the latch is ignored
		cmd(`FS2_OP_WRITE_ANY_REGISTER_CMD, `FS2_A_CONFIG_ONE_NONVOLATILE, 16'h0020);
		rd(`FS2_OP_READ_ANY_REGISTER_CMD, `FS2_A_CONFIG_ONE_NONVOLATILE, 8'h00);
		// random config writes by both commands, last one all zero
		ex = 8'h00;
		for (int i = 0; i < 6; i++) begin
			t = rnd();
			hybrid_map <= t[8];
			m = (i == 5) ? 8'h00 : (t[7:0] & 8'hfe);
			if (i[0]) wr(`FS2_OP_WRR, 8'h00, {m, 8'h00});
			else wr(`FS2_OP_WRITE_ANY_REGISTER_CMD, `FS2_A_CONFIG_ONE_NONVOLATILE, {8'h00, m});
			ex = ((ex | m) & 8'h2c) | (m & 8'h02);
			rd(`FS2_OP_READ_ANY_REGISTER_CMD, `FS2_A_CONFIG_ONE_NONVOLATILE, ex);
			chk("origin", {7'h0, pfb}, {7'h0, ex[5]});
			chk("params", {7'h0, pat}, {7'h0, ex[2] & t[8]});
		end
		// volatility bit forces nonvolatile protect to all ones
		wr(`FS2_OP_WRITE_ANY_REGISTER_CMD, `FS2_A_CONFIG_ONE_NONVOLATILE, 16'h0008);
		ex = ex | 8'h08;
		rd(`FS2_OP_READ_ANY_REGISTER_CMD, `FS2_A_CONFIG_ONE_NONVOLATILE, ex);
		cmd(`FS2_OP_SRST, 8'h00, 16'h0);
		rd(`FS2_OP_READ_ANY_REGISTER_CMD, `FS2_A_SR1V, 8'h1c);
		chk("range", {5'h0, prb}, 8'h07);
		// volatile mode writes volatile copy only
		wr(`FS2_OP_WRR, 8'h00, {ex & 8'hf6, 8'h04});
		rd(`FS2_OP_READ_ANY_REGISTER_CMD, `FS2_A_SR1V, 8'h04);
		cmd(`FS2_OP_SRST, 8'h00, 16'h0);
		rd(`FS2_OP_READ_ANY_REGISTER_CMD, `FS2_A_SR1V, 8'h1c);
		// four-wire default sets quad, active four-wire locks it
		wr(`FS2_OP_WRITE_ANY_REGISTER_CMD, `FS2_A_CONFIG_TWO_NONVOLATILE, 16'h0040);
		ex = ex | 8'h02;
		rd(`FS2_OP_READ_ANY_REGISTER_CMD, `FS2_A_CONFIG_ONE_NONVOLATILE, ex);
		wr(`FS2_OP_WRITE_ANY_REGISTER_CMD, `FS2_A_CONFIG_TWO_VOLATILE, 16'h0040);
		wr(`FS2_OP_WRITE_ANY_REGISTER_CMD, `FS2_A_CONFIG_ONE_NONVOLATILE, 16'h0000);
		wr(`FS2_OP_WRITE_ANY_REGISTER_CMD, `FS2_A_CONFIG_ONE_VOLATILE, 16'h0000);
		rd(`FS2_OP_READ_ANY_REGISTER_CMD, `FS2_A_CONFIG_ONE_NONVOLATILE, ex);
		chk("quad", {6'h0, quad, fw}, 8'h03);
		// unmapped controller address
		apb(0, 12'h0ff, 32'h0);
		chk("slverr", {7'h0, err}, 8'h01);
		chk("unmapped", r[7:0], 8'h00);
		repeat (4) @(posedge pclk);
		chk("pending", 8'(q.size()), 8'h00);
		report_and_stop();
	end
endmodule // testbench
